// file: inc/lcs_pkg.sv
package lcs_pkg;
  // Timebase
  localparam int CLK_HZ = 200_000_000;
  localparam int SEC_CYC = CLK_HZ;
  localparam int STEP_US = 400;
  localparam int STEP_CYC = CLK_HZ / 1_000_000 * STEP_US;
  localparam logic [15:0] DET_SEC = 16'h0002;
  localparam logic [15:0] OS_SEC = 16'h0001;
  // Cell thresholds and limits
  localparam logic [15:0] PRE_LO = 16'h39E6;
  localparam logic [15:0] PRE_HI = 16'h3AEA;
  localparam logic [4:0] VT_MAX = 5'h1F;
  localparam logic [4:0] DAC_MIN = 5'h01;
  localparam logic [4:0] PRE_DIV = 5'h0A;
  // Register offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_TGT = 8'h04;
  localparam logic [7:0] ADR_CVT = 8'h08;
  localparam logic [7:0] ADR_CHT = 8'h0C;
  localparam logic [7:0] ADR_BST = 8'h10;
  localparam logic [7:0] ADR_CX = 8'h14;
  localparam logic [7:0] ADR_STAT = 8'h18;
  localparam logic [7:0] ADR_ALRT = 8'h1C;
  // Field positions
  localparam int CTRL_SUSP = 0;
  localparam int CTRL_LFP = 1;
  localparam int CTRL_CX = 2;
  localparam int CTRL_AEN = 3;
  localparam int TGT_I = 0;
  localparam int TGT_V = 8;
  localparam int TGT_D = 16;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] TGT_RST = 32'h0000_1F1F;
  localparam logic [31:0] CVT_RST = 32'h0000_0E10;
  localparam logic [31:0] CHT_RST = 32'h0000_FD20;
  localparam logic [31:0] BST_RST = 32'h0000_0384;
  localparam logic [31:0] CX_RST = 32'h0000_0000;
  typedef enum logic [3:0] {
    ST_SUSP = 4'b0000,
    ST_DET = 4'b0001,
    ST_OS = 4'b0010,
    ST_BFLT = 4'b0011,
    ST_SS = 4'b0100,
    ST_PRE = 4'b0101,
    ST_BOOST = 4'b0110,
    ST_MAIN = 4'b0111,
    ST_DONE = 4'b1000,
    ST_TFLT = 4'b1001
  } lcs_state_t;
endpackage

// file: logic/lcs_sequencer.sv
`timescale 1ns/100ps
module lcs_sequencer
  import lcs_pkg::*;
#(
  parameter int SEC_CYC_P = SEC_CYC,
  parameter int STEP_CYC_P = STEP_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Analogue comparators and measurements
  input wire logic vin_near_bat,
  input wire logic sys_fault,
  input wire logic bat_stable,
  input wire logic bat_in_range,
  input wire logic thermistor_input_open,
  input wire logic sense_above_low,
  input wire logic battery_sense_pin_ok,
  input wire logic vbat_at_target,
  input wire logic vbat_below_low_frac,
  input wire logic input_limit_hit,
  input wire logic input_sag_feedback_pin_hit,
  input wire logic [15:0] filtered_cell_voltage_code,
  input wire logic [15:0] battery_current_reading,
  // Charger controls
  output logic charger_en,
  output logic load_draw_en,
  output logic min_current_en,
  output logic peak_current_mode,
  output logic [4:0] icharge_dac,
  output logic [4:0] vtarget_code,
  // Status
  output logic precharge_flag,
  output logic main_phase_flag,
  output logic boost_flag,
  output logic cv_flag,
  output logic iin_limit_active,
  output logic uvcl_active,
  output logic detect_alert
);

  localparam int NIN = 43;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic [1:0] rst_sync;
  logic rst_n;
  logic [NIN-1:0] in_s1;
  logic [NIN-1:0] in_s2;
  lcs_state_t state;
  lcs_state_t next_state;
  logic [31:0] r_ctrl;
  logic [31:0] r_tgt;
  logic [31:0] r_cvt;
  logic [31:0] r_cht;
  logic [31:0] r_bst;
  logic [31:0] r_cx;
  logic det_fault;
  logic [31:0] sec_cnt;
  logic [31:0] ph_cnt;
  logic [31:0] step_cnt;
  logic [15:0] ph_sec;
  logic [15:0] cv_sec;
  logic [15:0] chg_sec;
  logic cv_run;
  logic unstable;
  logic peak;
  logic [4:0] dac;

  // Reset release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Input synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_s1 <= '0;
      in_s2 <= '0;
    end else begin
      in_s1 <= {vin_near_bat, sys_fault, bat_stable, bat_in_range,
                thermistor_input_open, sense_above_low, battery_sense_pin_ok,
                vbat_at_target, vbat_below_low_frac, input_limit_hit,
                input_sag_feedback_pin_hit, filtered_cell_voltage_code,
                battery_current_reading};
      in_s2 <= in_s1;
    end
  end

  wire i_vnear = in_s2[42];
  wire i_sysf = in_s2[41];
  wire i_stable = in_s2[40];
  wire i_range = in_s2[39];
  wire i_ntc = in_s2[38];
  wire i_slow = in_s2[37];
  wire i_sok = in_s2[36];
  wire i_attgt = in_s2[35];
  wire i_low = in_s2[34];
  wire i_ilim = in_s2[33];
  wire i_sag = in_s2[32];
  wire [15:0] i_code = in_s2[31:16];
  wire [15:0] i_battery_current_reading = in_s2[15:0];

  // Register fields
  wire suspend = r_ctrl[CTRL_SUSP];
  wire lfp = r_ctrl[CTRL_LFP];
  wire cx_en = r_ctrl[CTRL_CX];
  wire alert_en = r_ctrl[CTRL_AEN];
  wire [4:0] tgt_i = r_tgt[TGT_I +: 5];
  wire [4:0] tgt_v = r_tgt[TGT_V +: 5];
  wire [4:0] tgt_d = r_tgt[TGT_D +: 5];
  wire [15:0] cvt_lim = r_cvt[15:0];
  wire [15:0] cht_lim = r_cht[15:0];
  wire [15:0] bst_lim = r_bst[15:0];
  wire [15:0] cx_lim = r_cx[15:0];

  // Events and decoded conditions
  wire stop_evt = i_vnear | suspend | i_sysf;
  wire ilow = i_battery_current_reading < cx_lim;
  wire pre_need = !lfp && (i_code < PRE_LO) && i_sok;
  wire pre_done = i_code > PRE_HI;
  wire boost_need = lfp && (tgt_d != 5'h00);
  wire [5:0] v_sum = {1'b0, tgt_v} + {1'b0, tgt_d};
  wire [4:0] v_boost = v_sum > {1'b0, VT_MAX} ? VT_MAX : v_sum[4:0];
  wire [4:0] pre_i = tgt_i / PRE_DIV;
  wire [4:0] ss_goal = pre_need ? pre_i : tgt_i;
  wire chg_st = (state == ST_SS) || (state == ST_PRE) ||
                (state == ST_BOOST) || (state == ST_MAIN);
  wire chg_on = chg_st || state == ST_OS;
  wire st_chg = state != next_state;
  wire sec_tick = sec_cnt == 32'(SEC_CYC_P - 1);
  wire ph_tick = ph_cnt == 32'(SEC_CYC_P - 1);
  wire step_tick = step_cnt == 32'(STEP_CYC_P - 1);
  wire cv_end = (cvt_lim != 16'h0000 || !lfp) && cv_sec >= cvt_lim;
  wire cx_end = cx_en && i_attgt && ilow;
  wire bst_end = ph_sec >= bst_lim || (i_attgt && ilow);
  wire over = chg_sec > cht_lim;
  wire limiting = i_ilim | i_sag;

  // Wishbone decode
  wire wb_req = wb_cyc_i & wb_stb_i & !wb_ack_o;
  wire wb_wr = wb_req & wb_we_i;
  wire wr_ctrl = wb_wr && wb_adr_i == ADR_CTRL;
  wire wr_tgt = wb_wr && wb_adr_i == ADR_TGT;
  wire wr_cvt = wb_wr && wb_adr_i == ADR_CVT;
  wire wr_cht = wb_wr && wb_adr_i == ADR_CHT;
  wire wr_bst = wb_wr && wb_adr_i == ADR_BST;
  wire wr_cx = wb_wr && wb_adr_i == ADR_CX;
  wire clr_alrt = wb_wr && wb_adr_i == ADR_ALRT && wb_sel_i[0] && wb_dat_i[0];
  wire [31:0] stat_word = {18'h0, det_fault, peak, uvcl_active,
                           iin_limit_active, cv_flag, boost_flag,
                           main_phase_flag, precharge_flag, 2'b00, state};
  wire [31:0] rd_data =
    wb_adr_i == ADR_CTRL ? r_ctrl :
    wb_adr_i == ADR_TGT ? r_tgt :
    wb_adr_i == ADR_CVT ? r_cvt :
    wb_adr_i == ADR_CHT ? r_cht :
    wb_adr_i == ADR_BST ? r_bst :
    wb_adr_i == ADR_CX ? r_cx :
    wb_adr_i == ADR_STAT ? stat_word :
    wb_adr_i == ADR_ALRT ? {31'h0, det_fault} : 32'h0000_0000;

  // Bus answer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_data : 32'h0000_0000;
    end
  end

  // Software registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_ctrl <= CTRL_RST;
      r_tgt <= TGT_RST;
      r_cvt <= CVT_RST;
      r_cht <= CHT_RST;
      r_bst <= BST_RST;
      r_cx <= CX_RST;
    end else begin
      if (wr_ctrl) begin
        r_ctrl <= merge(r_ctrl, wb_dat_i, wb_sel_i) & 32'h0000_000F;
      end
      if (wr_tgt) begin
        r_tgt <= merge(r_tgt, wb_dat_i, wb_sel_i) & 32'h001F_1F1F;
      end
      if (wr_cvt) begin
        r_cvt <= merge(r_cvt, wb_dat_i, wb_sel_i) & 32'h0000_FFFF;
      end
      if (wr_cht) begin
        r_cht <= merge(r_cht, wb_dat_i, wb_sel_i) & 32'h0000_FFFF;
      end
      if (wr_bst) begin
        r_bst <= merge(r_bst, wb_dat_i, wb_sel_i) & 32'h0000_FFFF;
      end
      if (wr_cx) begin
        r_cx <= merge(r_cx, wb_dat_i, wb_sel_i) & 32'h0000_FFFF;
      end
    end
  end

  // Sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      ST_SUSP: begin
        if (!stop_evt) begin
          next_state = ST_DET;
        end
      end
      ST_DET: begin
        if (i_ntc) begin
          next_state = ST_BFLT;
        end else if (ph_sec >= DET_SEC) begin
          next_state = (unstable || !i_stable) ? ST_OS : ST_SS;
        end
      end
      ST_OS: begin
        if (ph_sec >= OS_SEC) begin
          next_state = i_range ? ST_SS : ST_BFLT;
        end
      end
      ST_BFLT: begin
        next_state = ST_BFLT;
      end
      ST_SS: begin
        if (dac == ss_goal) begin
          next_state = pre_need ? ST_PRE : boost_need ? ST_BOOST : ST_MAIN;
        end
      end
      ST_PRE: begin
        if (pre_done) begin
          next_state = ST_MAIN;
        end
      end
      ST_BOOST: begin
        if (bst_end) begin
          next_state = ST_MAIN;
        end
      end
      ST_MAIN: begin
        if (cv_end || cx_end) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_DONE;
      end
      ST_TFLT: begin
        if (i_low) begin
          next_state = ST_DET;
        end
      end
      default: begin
        next_state = ST_SUSP;
      end
    endcase
    if (chg_st && over) begin
      next_state = ST_TFLT;
    end
    if (stop_evt) begin
      next_state = ST_SUSP;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_SUSP;
    end else begin
      state <= next_state;
    end
  end

  // Timebase prescalers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_cnt <= 32'h0000_0000;
      ph_cnt <= 32'h0000_0000;
      step_cnt <= 32'h0000_0000;
    end else begin
      sec_cnt <= sec_tick ? 32'h0000_0000 : sec_cnt + 32'h0000_0001;
      ph_cnt <= (st_chg || ph_tick) ? 32'h0000_0000 : ph_cnt + 32'h0000_0001;
      step_cnt <= step_tick ? 32'h0000_0000 : step_cnt + 32'h0000_0001;
    end
  end

  // Phase, hold and charge timers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_sec <= 16'h0000;
      cv_sec <= 16'h0000;
      chg_sec <= 16'h0000;
      cv_run <= 1'b0;
      unstable <= 1'b0;
    end else begin
      if (st_chg) begin
        ph_sec <= 16'h0000;
      end else if (ph_tick && ph_sec != 16'hFFFF) begin
        ph_sec <= ph_sec + 16'h0001;
      end
      if (state != ST_MAIN) begin
        cv_run <= 1'b0;
        cv_sec <= 16'h0000;
      end else begin
        cv_run <= cv_run | i_attgt;
        if (cv_run && sec_tick && cv_sec != 16'hFFFF) begin
          cv_sec <= cv_sec + 16'h0001;
        end
      end
      if (next_state == ST_DET || next_state == ST_DONE) begin
        chg_sec <= 16'h0000;
      end else if (chg_st && sec_tick && chg_sec != 16'hFFFF) begin
        chg_sec <= chg_sec + 16'h0001;
      end
      if (state != ST_DET) begin
        unstable <= 1'b0;
      end else if (!i_stable) begin
        unstable <= 1'b1;
      end
    end
  end

  // Current setpoint ramp and input limit backoff
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dac <= 5'h00;
    end else if (!chg_st) begin
      dac <= 5'h00;
    end else if (step_tick) begin
      if (limiting && dac > DAC_MIN) begin
        dac <= dac - 5'h01;
      end else if (!limiting && dac < ss_goal_now(state)) begin
        dac <= dac + 5'h01;
      end else if (dac > ss_goal_now(state)) begin
        dac <= ss_goal_now(state);
      end
    end
  end

  function automatic logic [4:0] ss_goal_now(input lcs_state_t s);
    logic [4:0] g;
    g = tgt_i;
    if (s == ST_SS) begin
      g = ss_goal;
    end else if (s == ST_PRE) begin
      g = pre_i;
    end
    return g;
  endfunction

  // Peak current hysteresis
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      peak <= 1'b0;
    end else if (!i_slow) begin
      peak <= 1'b1;
    end else if (i_sok) begin
      peak <= 1'b0;
    end
  end

  // Detection fault alert, set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      det_fault <= 1'b0;
    end else if (next_state == ST_BFLT && state != ST_BFLT) begin
      det_fault <= 1'b1;
    end else if (clr_alrt) begin
      det_fault <= 1'b0;
    end
  end

  // Registered outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      charger_en <= 1'b0;
      load_draw_en <= 1'b0;
      min_current_en <= 1'b0;
      peak_current_mode <= 1'b0;
      icharge_dac <= 5'h00;
      vtarget_code <= 5'h00;
      precharge_flag <= 1'b0;
      main_phase_flag <= 1'b0;
      boost_flag <= 1'b0;
      cv_flag <= 1'b0;
      iin_limit_active <= 1'b0;
      uvcl_active <= 1'b0;
      detect_alert <= 1'b0;
    end else begin
      charger_en <= chg_on;
      load_draw_en <= state == ST_DET;
      min_current_en <= state == ST_OS;
      peak_current_mode <= peak && chg_on;
      icharge_dac <= state == ST_OS ? DAC_MIN : dac;
      vtarget_code <= state == ST_BOOST ? v_boost : tgt_v;
      precharge_flag <= state == ST_PRE;
      main_phase_flag <= state == ST_MAIN;
      boost_flag <= state == ST_BOOST;
      cv_flag <= (state == ST_BOOST || state == ST_MAIN) && i_attgt;
      iin_limit_active <= chg_on && i_ilim;
      uvcl_active <= chg_on && i_sag;
      detect_alert <= det_fault && alert_en;
    end
  end

endmodule

// file: test/lcs_sequencer_asserts.sv
`timescale 1ns/100ps
module lcs_sequencer_asserts
  import lcs_pkg::*;
#(
  parameter int SEC_CYC_P = SEC_CYC,
  parameter int STEP_CYC_P = STEP_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Analogue inputs
  input wire logic vin_near_bat,
  input wire logic sys_fault,
  input wire logic sense_above_low,
  input wire logic input_limit_hit,
  // Controls and status
  input wire logic charger_en,
  input wire logic load_draw_en,
  input wire logic min_current_en,
  input wire logic peak_current_mode,
  input wire logic [4:0] icharge_dac,
  input wire logic precharge_flag,
  input wire logic main_phase_flag,
  input wire logic boost_flag,
  input wire logic iin_limit_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_vin_held;
    vin_near_bat [*6];
  endsequence
  sequence s_fault_held;
    sys_fault [*6];
  endsequence
  sequence s_low_sense;
    (charger_en && !sense_above_low) [*6];
  endsequence
  sequence s_limit_held;
    (charger_en && input_limit_hit) [*6];
  endsequence
  AST_ACK_NEXT: assert property (s_req |=> wb_ack_o)
    else $error("bus request not answered in the next cycle");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside acknowledge");
  AST_VIN_SUSP: assert property (s_vin_held |-> !charger_en && !load_draw_en)
    else $error("charger active while input near battery");
  AST_FAULT_SUSP: assert property (s_fault_held |-> !charger_en && !min_current_en)
    else $error("charger active during system fault");
  AST_MIN_DAC: assert property (min_current_en |-> icharge_dac == DAC_MIN)
    else $error("open/short test not at minimum current");
  AST_DAC_RAMP: assert property ((icharge_dac > $past(icharge_dac)) && !main_phase_flag
    && !boost_flag && !precharge_flag |-> icharge_dac == $past(icharge_dac) + 5'h01)
    else $error("soft-start step larger than one");
  AST_PRE_EXCL: assert property (precharge_flag |-> !main_phase_flag && !boost_flag)
    else $error("precharge flag together with another phase");
  AST_PEAK: assert property (s_low_sense |-> peak_current_mode)
    else $error("peak current mode missing with low sense pin");
  AST_ILIM: assert property (s_limit_held |-> iin_limit_active)
    else $error("input limit flag missing");
endmodule

bind lcs_sequencer lcs_sequencer_asserts #(
  .SEC_CYC_P(SEC_CYC_P),
  .STEP_CYC_P(STEP_CYC_P)
) lcs_sequencer_asserts_inst (
  .clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .vin_near_bat, .sys_fault,
  .sense_above_low, .input_limit_hit, .charger_en, .load_draw_en, .min_current_en,
  .peak_current_mode, .icharge_dac, .precharge_flag, .main_phase_flag, .boost_flag,
  .iin_limit_active
);

// file: test/lcs_charger_model.sv
`timescale 1ns/100ps
module lcs_charger_model (
  // Clock and bench knobs
  input wire logic clk,
  input wire logic load,
  input wire logic [15:0] start_code,
  input wire logic [1:0] mode,
  // Charger controls
  input wire logic charger_en,
  input wire logic [4:0] icharge_dac,
  input wire logic [4:0] vtarget_code,
  // Measurements
  output logic bat_stable,
  output logic bat_in_range,
  output logic sense_above_low,
  output logic battery_sense_pin_ok,
  output logic vbat_at_target,
  output logic vbat_below_low_frac,
  output logic [15:0] filtered_cell_voltage_code,
  output logic [15:0] battery_current_reading
);
  logic [15:0] code;
  // Battery charges by the setpoint each cycle until it sits at target
  always_ff @(posedge clk) begin
    if (load) begin
      code <= start_code;
    end else if (charger_en && !vbat_at_target) begin
      code <= code + {11'h000, icharge_dac};
    end
  end
  assign vbat_at_target = code >= {2'h0, vtarget_code, 9'h000};
  assign bat_stable = !mode[0];
  assign bat_in_range = !mode[1];
  assign sense_above_low = code > 16'h1800;
  assign battery_sense_pin_ok = code > 16'h1A00;
  assign vbat_below_low_frac = code < 16'h1500;
  assign filtered_cell_voltage_code = code;
  assign battery_current_reading = (charger_en && !vbat_at_target) ?
    {3'h0, icharge_dac, 8'h00} : 16'h0000;
endmodule

// file: test/lcs_sequencer_bench.sv
`timescale 1ns/100ps
module lcs_sequencer_bench
  import lcs_pkg::*;
;
  localparam int SEC_P = 20;
  typedef struct packed {
    logic we;
    logic [7:0] adr;
    logic [31:0] dat;
    logic [31:0] exp;
  } lcs_row_t;
  localparam lcs_row_t ROWS [12] = '{
    '{1'h0, ADR_CTRL, 32'h0000_0000, CTRL_RST}, '{1'h0, ADR_TGT, 32'h0000_0000, TGT_RST},
    '{1'h0, ADR_CVT, 32'h0000_0000, CVT_RST}, '{1'h0, ADR_CHT, 32'h0000_0000, CHT_RST},
    '{1'h0, ADR_BST, 32'h0000_0000, BST_RST}, '{1'h0, ADR_CX, 32'h0000_0000, CX_RST},
    '{1'h1, 8'h20, 32'hFFFF_FFFF, 32'h0000_0000}, '{1'h0, 8'h20, 32'h0000_0000, 32'h0000_0000},
    '{1'h1, ADR_CVT, 32'h0000_0002, 32'h0000_0000}, '{1'h0, ADR_CVT, 32'h0000_0000, 32'h0000_0002},
    '{1'h1, ADR_CX, 32'h0000_0100, 32'h0000_0000}, '{1'h0, ADR_CX, 32'h0000_0000, 32'h0000_0100}
  };
  logic clk = 1'h0, nrst = 1'h0, load = 1'h1;
  logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q;
  logic vin_near_bat = 1'h0, sys_fault = 1'h1, thermistor_input_open = 1'h0;
  logic input_limit_hit = 1'h0, input_sag_feedback_pin_hit = 1'h0;
  logic [1:0] mode = 2'h0;
  logic [15:0] start_code = 16'h3000, filtered_cell_voltage_code, battery_current_reading;
  logic bat_stable, bat_in_range, sense_above_low, battery_sense_pin_ok, vbat_at_target;
  logic vbat_below_low_frac, charger_en, load_draw_en, min_current_en, peak_current_mode;
  logic [4:0] icharge_dac, vtarget_code;
  logic precharge_flag, main_phase_flag, boost_flag, cv_flag, iin_limit_active, uvcl_active;
  logic detect_alert;
  int miscompares = 0, checks = 0, n;
  always #2.5 clk = ~clk;
  lcs_sequencer #(.SEC_CYC_P(SEC_P), .STEP_CYC_P(4)) lcs_sequencer_inst (
    .clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .vin_near_bat, .sys_fault, .bat_stable, .bat_in_range, .thermistor_input_open,
    .sense_above_low, .battery_sense_pin_ok, .vbat_at_target, .vbat_below_low_frac,
    .input_limit_hit, .input_sag_feedback_pin_hit, .filtered_cell_voltage_code,
    .battery_current_reading, .charger_en, .load_draw_en, .min_current_en, .peak_current_mode,
    .icharge_dac, .vtarget_code, .precharge_flag, .main_phase_flag, .boost_flag, .cv_flag,
    .iin_limit_active, .uvcl_active, .detect_alert);
  lcs_charger_model lcs_charger_model_inst (
    .clk, .load, .start_code, .mode, .charger_en, .icharge_dac, .vtarget_code, .bat_stable,
    .bat_in_range, .sense_above_low, .battery_sense_pin_ok, .vbat_at_target,
    .vbat_below_low_frac, .filtered_cell_voltage_code, .battery_current_reading);
  task automatic print_verdict();
    $display("Compares %0d, mismatches %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Classic single cycle, held until acknowledge is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk);
    while (wb_ack_o !== 1'h1 && k < 20) begin
      @(posedge clk);
      k++;
    end
    check({31'h0, k < 20}, 32'h0000_0001);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge clk);
  endtask
  task automatic state_is(input lcs_state_t s);
    wb(1'h0, ADR_STAT, 32'h0000_0000);
    check({28'h000_0000, q[3:0]}, {28'h000_0000, s});
  endtask
  function automatic logic probe(input int k);
    case (k)
      0: return load_draw_en;
      1: return precharge_flag;
      2: return main_phase_flag;
      3: return boost_flag;
      5: return min_current_en;
      6: return detect_alert;
      default: return charger_en;
    endcase
  endfunction
  task automatic wait_sig(input int k, input logic v);
    int c;
    c = 0;
    while (probe(k) !== v && c < 5000) begin
      @(posedge clk);
      c++;
    end
    check({31'h0, c < 5000}, 32'h0000_0001);
  endtask
  // Suspend, clear the alert, then resume with the given control word
  task automatic restart(input logic [31:0] c);
    wb(1'h1, ADR_CTRL, c | 32'h0000_0001);
    wb(1'h1, ADR_ALRT, 32'h0000_0001);
    wb(1'h1, ADR_CTRL, c);
  endtask
  task automatic set_code(input logic [15:0] v);
    start_code <= v;
    load <= 1'h1;
    @(posedge clk);
    load <= 1'h0;
  endtask
  task automatic set_event(input int k, input logic v);
    if (k == 0) begin
      wb(1'h1, ADR_CTRL, {31'h0, v});
    end else if (k == 1) begin
      vin_near_bat <= v;
    end else begin
      sys_fault <= v;
    end
  endtask
  // Whole run needs well under 20000 cycles
  initial begin
    #400_000;
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'h1;
    load <= 1'h0;
    repeat (3) @(posedge clk);
    foreach (ROWS[i]) begin
      wb(ROWS[i].we, ROWS[i].adr, ROWS[i].dat);
      if (!ROWS[i].we) check(q, ROWS[i].exp);
    end
    state_is(ST_SUSP);
    sys_fault <= 1'h0;
    wait_sig(0, 1'h1);
    check({31'h0, charger_en}, 32'h0000_0000);
    n = 0;
    while (load_draw_en === 1'h1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    check({31'h0, n >= 2 * SEC_P && n <= 4 * SEC_P}, 32'h0000_0001);
    wait_sig(1, 1'h1);
    check({27'h0, icharge_dac}, 32'h0000_0003);
    input_limit_hit <= 1'h1;
    repeat (12) @(posedge clk);
    check({31'h0, iin_limit_active}, 32'h0000_0001);
    check({31'h0, icharge_dac < 5'h03}, 32'h0000_0001);
    input_limit_hit <= 1'h0;
    input_sag_feedback_pin_hit <= 1'h1;
    repeat (12) @(posedge clk);
    check({31'h0, uvcl_active}, 32'h0000_0001);
    input_sag_feedback_pin_hit <= 1'h0;
    wait_sig(2, 1'h1);
    check({31'h0, precharge_flag}, 32'h0000_0000);
    wait_sig(4, 1'h0);
    state_is(ST_DONE);
    for (int k = 0; k < 3; k++) begin
      set_event(k, 1'h1);
      repeat (6) @(posedge clk);
      state_is(ST_SUSP);
      set_event(k, 1'h0);
      wait_sig(0, 1'h1);
    end
    thermistor_input_open <= 1'h1;
    restart(32'h0000_0008);
    wait_sig(6, 1'h1);
    state_is(ST_BFLT);
    check({31'h0, charger_en}, 32'h0000_0000);
    thermistor_input_open <= 1'h0;
    mode <= 2'h1;
    restart(32'h0000_0008);
    check({31'h0, detect_alert}, 32'h0000_0000);
    wait_sig(5, 1'h1);
    check({27'h0, icharge_dac}, 32'h0000_0001);
    wait_sig(5, 1'h0);
    check({31'h0, charger_en}, 32'h0000_0001);
    mode <= 2'h3;
    restart(32'h0000_0008);
    wait_sig(6, 1'h1);
    state_is(ST_BFLT);
    mode <= 2'h0;
    set_code(16'h1C00);
    wb(1'h1, ADR_CVT, 32'h0000_0000);
    wb(1'h1, ADR_TGT, 32'h0005_1C1F);
    restart(32'h0000_0002);
    wait_sig(3, 1'h1);
    check({27'h0, vtarget_code}, 32'h0000_001F);
    check({27'h0, icharge_dac}, 32'h0000_001F);
    check({31'h0, precharge_flag}, 32'h0000_0000);
    wait_sig(3, 1'h0);
    check({27'h0, vtarget_code}, 32'h0000_001C);
    repeat (200) @(posedge clk);
    state_is(ST_MAIN);
    check({31'h0, cv_flag}, 32'h0000_0001);
    wb(1'h1, ADR_CTRL, 32'h0000_0006);
    repeat (6) @(posedge clk);
    state_is(ST_DONE);
    set_code(16'h3000);
    wb(1'h1, ADR_TGT, TGT_RST);
    wb(1'h1, ADR_CHT, 32'h0000_0001);
    restart(32'h0000_0000);
    wait_sig(4, 1'h1);
    wait_sig(4, 1'h0);
    state_is(ST_TFLT);
    set_code(16'h1000);
    wait_sig(0, 1'h1);
    wb(1'h1, ADR_CHT, 32'h0000_0064);
    wait_sig(4, 1'h1);
    repeat (6) @(posedge clk);
    check({31'h0, peak_current_mode}, 32'h0000_0001);
    // Mid-run reset drops the charger at once and restores the registers
    nrst <= 1'h0;
    @(posedge clk);
    check({31'h0, charger_en}, 32'h0000_0000);
    check({27'h0, icharge_dac}, 32'h0000_0000);
    nrst <= 1'h1;
    repeat (3) @(posedge clk);
    wb(1'h0, ADR_CHT, 32'h0000_0000);
    check(q, CHT_RST);
    print_verdict();
  end
endmodule
